/* File: hdl/timer_pulse_pwm.sv */
// 16-bit timer with single pulse and pwm modes, apb register slave
// Function
// R1: single_pulse_select makes capture 1 input and compare 1 output work as a pulse generator.
// R2: single pulse trigger stores count, reloads FFFC, drives compare2 level, sets capture1 flag.
// R3: capture1 flag from a trigger requests an interrupt when capture interrupts are enabled.
// R4: capture flag clears after status read while set, then access to capture low byte.
// R5: single pulse: counter equal to compare1 value drives compare1 level, ending pulse.
// R6: software loads compare value as duration times timer rate minus five.
// R7: single pulse never sets compare1 flag; compare2 flag still sets and interrupts.
// R8: pwm select together with single pulse select gives pwm mode only.
// R9: in pulse or pwm mode equal levels hold compare1 pin constant.
// R10: pulse and pwm modes: no capture 1; capture 2 still loads value and flag.
// R11: single pulse: compare2 still flags elapsed time but drives no waveform.
// R12: pwm: compare2 sets period, compare1 sets pulse edge.
// R13: pwm: new compare values reach shadows only at the compare2 match.
// R14: compare high write blocks shadow transfer until low byte written.
// R15: pwm comparison stays active despite a high byte write inhibit.
// R16: pwm: pin takes compare1 level at compare1 match, compare2 level at compare2.
// R17: pwm: compare2 match reloads counter with FFFC.
// R18: pwm: compare1 and compare2 flags never set.
// R19: pwm: compare2 match sets capture1 flag and interrupts when enabled and unmasked.
// R20: timer runs in wait; an enabled timer interrupt wakes the device.
// R21: halt freezes counter and registers; resume from held count, or reset value.
// R22: capture edge in halt arms detection; halt exit sets flag and captures count.
// R23: clock select gives cpu clock over four, two, eight, or external clock.
// R24: single pulse trigger edge is chosen by capture1_edge_select.
// R25: counter increments each timer tick and wraps when not reloaded.
module timer_pulse_pwm
  import timer_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  apb_req_type apb_req,
  output apb_rsp_type apb_rsp,
  input  wire logic  capture1_pin,
  input  wire logic  capture2_pin,
  input  wire logic  ext_clk_pin,
  input  wire logic  halt_state,
  input  wire logic  wait_state,
  input  wire logic  irq_mask,
  output logic       compare1_pin,
  output logic       compare1_pin_oe,
  output logic       timer_irq,
  output logic       wait_wake
);

  function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
    edge_hit = rising ? (cur & ~prev) : (~cur & prev);
  endfunction

  logic [7:0]  timer_control_one_q;
  logic [7:0]  timer_control_two_q;
  logic [15:0] compare1_value_q;
  logic [15:0] compare2_value_q;
  logic [15:0] shadow1_q;
  logic [15:0] shadow2_q;
  logic [1:0]  compare_lock_q;
  logic [15:0] count_q;
  logic [15:0] capture1_value_q;
  logic [15:0] capture2_value_q;
  logic [1:0]  capture_lock_q;
  logic [1:0]  capture_flag_q;
  logic [1:0]  compare_flag_q;
  logic [1:0]  capture_clr_arm_q;
  logic [1:0]  compare_clr_arm_q;
  logic [1:0]  halt_arm_q;
  logic        halt_prev_q;
  logic        pin_q;
  logic        irq_q;
  logic [1:0]  cap_meta_q;
  logic [1:0]  cap_sync_q;
  logic [1:0]  cap_prev_q;
  logic [31:0] rdata_q;
  logic        slverr_q;

  logic        tick;
  logic        running;
  logic        halt_exit;
  mode_type    mode;
  logic        level1;
  logic        level2;
  logic        cap1_edge;
  logic        cap2_edge;
  logic        normal_cap1;
  logic        trigger;
  logic        cap2_event;
  logic [15:0] ref1;
  logic [15:0] ref2;
  logic        match1;
  logic        match2;
  logic        period_end;
  logic [1:0]  capture_set;
  logic [1:0]  compare_set;
  logic [1:0]  capture_clr;
  logic [1:0]  compare_clr;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wbyte;
  logic [31:0] rmux;
  logic        mapped;

  assign setup  = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wr     = access & apb_req.pwrite;
  assign rd     = access & ~apb_req.pwrite;
  assign addr   = apb_req.paddr;
  assign wbyte  = apb_req.pwdata[7:0];

  assign level1 = timer_control_one_q[COMPARE1_LEVEL_BIT];
  assign level2 = timer_control_one_q[COMPARE2_LEVEL_BIT];

  // pwm select wins over single pulse select
  always_comb begin
    if (timer_control_two_q[PWM_SELECT_BIT]) begin // R8
      mode = MODE_PWM;
    end else if (timer_control_two_q[SINGLE_PULSE_SELECT_BIT]) begin // R1
      mode = MODE_SINGLE;
    end else begin
      mode = MODE_NORMAL;
    end
  end

  timer_tick_gen u_tick (
    .clk             (clk),
    .rst_b           (rst_b),
    .clock_select    (timer_control_two_q[TIMER_CLOCK_SELECT_LSB +: 2]),
    .ext_edge_rising (timer_control_two_q[EXT_CLOCK_EDGE_BIT]),
    .ext_clk_pin     (ext_clk_pin),
    .freeze          (halt_state),
    .tick            (tick)
  );

  // capture pins are asynchronous
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cap_meta_q <= 2'h0;
      cap_sync_q <= 2'h0;
      cap_prev_q <= 2'h0;
    end else begin
      cap_meta_q <= {capture2_pin, capture1_pin};
      cap_sync_q <= cap_meta_q;
      cap_prev_q <= cap_sync_q;
    end
  end

  assign running   = ~halt_state; // R21
  assign halt_exit = halt_prev_q & ~halt_state;
  assign cap1_edge = edge_hit(cap_prev_q[0], cap_sync_q[0], timer_control_one_q[CAPTURE1_EDGE_SELECT_BIT]); // R24
  assign cap2_edge = edge_hit(cap_prev_q[1], cap_sync_q[1], timer_control_two_q[CAPTURE2_EDGE_SELECT_BIT]);

  assign normal_cap1 = running & (mode == MODE_NORMAL) & cap1_edge & ~capture_lock_q[0]; // R10
  assign trigger     = running & (mode == MODE_SINGLE) & cap1_edge; // R2
  assign cap2_event  = running & cap2_edge & ~capture_lock_q[1]; // R10

  // pwm compares against the shadows, other modes against the live values
  assign ref1 = (mode == MODE_PWM) ? shadow1_q : compare1_value_q; // R12
  assign ref2 = (mode == MODE_PWM) ? shadow2_q : compare2_value_q; // R12
  assign match1 = tick & (count_q == ref1) & ((mode == MODE_PWM) | ~compare_lock_q[0]); // R15
  assign match2 = tick & (count_q == ref2) & ((mode == MODE_PWM) | ~compare_lock_q[1]); // R15
  assign period_end = (mode == MODE_PWM) & match2;

  assign capture_set[0] = normal_cap1 | trigger | period_end | (halt_exit & halt_arm_q[0]); // R2 R19 R22
  assign capture_set[1] = cap2_event | (halt_exit & halt_arm_q[1]); // R10 R22
  assign compare_set[0] = match1 & (mode == MODE_NORMAL); // R7 R18
  assign compare_set[1] = match2 & (mode != MODE_PWM); // R11 R18

  assign capture_clr[0] = access & (addr == CAPTURE1_LOW_OFFSET) & capture_clr_arm_q[0]; // R4
  assign capture_clr[1] = access & (addr == CAPTURE2_LOW_OFFSET) & capture_clr_arm_q[1]; // R4
  assign compare_clr[0] = access & (addr == COMPARE1_LOW_OFFSET) & compare_clr_arm_q[0];
  assign compare_clr[1] = access & (addr == COMPARE2_LOW_OFFSET) & compare_clr_arm_q[1];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_control_one_q <= CONTROL_RESET;
      timer_control_two_q <= CONTROL_RESET;
    end else if (wr && addr == CONTROL_ONE_OFFSET) begin
      timer_control_one_q <= wbyte;
    end else if (wr && addr == CONTROL_TWO_OFFSET) begin
      timer_control_two_q <= wbyte;
    end
  end

  // compare values and the high-byte lock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compare1_value_q <= COMPARE_RESET;
      compare2_value_q <= COMPARE_RESET;
      compare_lock_q   <= 2'h0;
    end else begin
      if (wr && addr == COMPARE1_HIGH_OFFSET) begin
        compare1_value_q[15:8] <= wbyte;
        compare_lock_q[0]      <= 1'b1; // R14
      end
      if (wr && addr == COMPARE1_LOW_OFFSET) begin
        compare1_value_q[7:0] <= wbyte;
        compare_lock_q[0]     <= 1'b0; // R14
      end
      if (wr && addr == COMPARE2_HIGH_OFFSET) begin
        compare2_value_q[15:8] <= wbyte;
        compare_lock_q[1]      <= 1'b1; // R14
      end
      if (wr && addr == COMPARE2_LOW_OFFSET) begin
        compare2_value_q[7:0] <= wbyte;
        compare_lock_q[1]     <= 1'b0; // R14
      end
    end
  end

  // shadows follow the live values outside pwm so a new pwm run starts cleanly
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shadow1_q <= COMPARE_RESET;
      shadow2_q <= COMPARE_RESET;
    end else if (mode != MODE_PWM || period_end) begin // R13
      if (!compare_lock_q[0]) begin // R14
        shadow1_q <= compare1_value_q;
      end
      if (!compare_lock_q[1]) begin // R14
        shadow2_q <= compare2_value_q;
      end
    end
  end

  // trigger and period end reload; the reload offset is why software subtracts five
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= COUNTER_RESET; // R21
    end else if (trigger || period_end) begin
      count_q <= COUNTER_RELOAD; // R2 R17
    end else if (tick) begin
      count_q <= count_q + 16'h0001; // R25
    end
  end

  // capture registers; a high-byte read inhibits new edge captures until the low byte is accessed; trigger and halt-exit loads ignore it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      capture1_value_q <= 16'h0000;
      capture2_value_q <= 16'h0000;
      capture_lock_q   <= 2'h0;
    end else begin
      if (normal_cap1 || trigger || (halt_exit && halt_arm_q[0])) begin // R2 R22
        capture1_value_q <= count_q;
      end
      if (cap2_event || (halt_exit && halt_arm_q[1])) begin // R10 R22
        capture2_value_q <= count_q;
      end
      if (rd && addr == CAPTURE1_HIGH_OFFSET) begin
        capture_lock_q[0] <= 1'b1;
      end else if (access && addr == CAPTURE1_LOW_OFFSET) begin
        capture_lock_q[0] <= 1'b0;
      end
      if (rd && addr == CAPTURE2_HIGH_OFFSET) begin
        capture_lock_q[1] <= 1'b1;
      end else if (access && addr == CAPTURE2_LOW_OFFSET) begin
        capture_lock_q[1] <= 1'b0;
      end
    end
  end

  // capture 2 edges, and capture 1 edges in normal mode, seen while halted are held until the wake-up
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halt_arm_q  <= 2'h0;
      halt_prev_q <= 1'b0;
    end else begin
      halt_prev_q <= halt_state;
      if (halt_exit) begin
        halt_arm_q <= 2'h0;
      end else if (halt_state) begin
        halt_arm_q[0] <= halt_arm_q[0] | (cap1_edge & (mode == MODE_NORMAL)); // R22
        halt_arm_q[1] <= halt_arm_q[1] | cap2_edge; // R22
      end
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      capture_flag_q <= 2'h0;
      compare_flag_q <= 2'h0;
    end else begin
      capture_flag_q <= capture_set | (capture_flag_q & ~capture_clr); // R4
      compare_flag_q <= compare_set | (compare_flag_q & ~compare_clr);
    end
  end

  // status read arms clearing only for flags it showed as set
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      capture_clr_arm_q <= 2'h0;
      compare_clr_arm_q <= 2'h0;
    end else if (rd && addr == STATUS_OFFSET) begin
      capture_clr_arm_q <= capture_clr_arm_q | {rdata_q[CAPTURE2_FLAG_BIT], rdata_q[CAPTURE1_FLAG_BIT]}; // R4
      compare_clr_arm_q <= compare_clr_arm_q | {rdata_q[COMPARE2_FLAG_BIT], rdata_q[COMPARE1_FLAG_BIT]};
    end else begin
      capture_clr_arm_q <= capture_clr_arm_q & ~capture_clr;
      compare_clr_arm_q <= compare_clr_arm_q & ~compare_clr;
    end
  end

  // compare1 pin waveform
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_q <= 1'b0;
    end else if (mode != MODE_NORMAL && level1 == level2) begin
      pin_q <= level1; // R9
    end else begin
      unique case (mode)
        MODE_SINGLE: begin
          if (trigger) begin
            pin_q <= level2; // R2
          end else if (match1) begin
            pin_q <= level1; // R5
          end
        end
        MODE_PWM: begin
          if (match2) begin
            pin_q <= level2; // R16
          end else if (match1) begin
            pin_q <= level1; // R16
          end
        end
        MODE_NORMAL: begin
          if (match1) begin
            pin_q <= level1;
          end
        end
      endcase
    end
  end

  assign compare1_pin    = pin_q;
  assign compare1_pin_oe = timer_control_two_q[COMPARE1_PIN_ENABLE_BIT];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ~irq_mask & ((timer_control_one_q[CAPTURE_IRQ_ENABLE_BIT] & (|capture_flag_q)) // R3 R19
                          | (timer_control_one_q[COMPARE_IRQ_ENABLE_BIT] & (|compare_flag_q))); // R7
    end
  end

  assign timer_irq = irq_q;
  assign wait_wake = irq_q & wait_state; // R20

  always_comb begin
    mapped = 1'b1;
    rmux   = 32'h0000_0000;
    unique case (addr)
      CONTROL_ONE_OFFSET:   rmux[7:0] = timer_control_one_q;
      CONTROL_TWO_OFFSET:   rmux[7:0] = timer_control_two_q;
      STATUS_OFFSET: begin
        rmux[CAPTURE1_FLAG_BIT] = capture_flag_q[0];
        rmux[COMPARE1_FLAG_BIT] = compare_flag_q[0];
        rmux[CAPTURE2_FLAG_BIT] = capture_flag_q[1];
        rmux[COMPARE2_FLAG_BIT] = compare_flag_q[1];
      end
      COMPARE1_HIGH_OFFSET: rmux[7:0] = compare1_value_q[15:8];
      COMPARE1_LOW_OFFSET:  rmux[7:0] = compare1_value_q[7:0];
      COMPARE2_HIGH_OFFSET: rmux[7:0] = compare2_value_q[15:8];
      COMPARE2_LOW_OFFSET:  rmux[7:0] = compare2_value_q[7:0];
      CAPTURE1_HIGH_OFFSET: rmux[7:0] = capture1_value_q[15:8];
      CAPTURE1_LOW_OFFSET:  rmux[7:0] = capture1_value_q[7:0];
      CAPTURE2_HIGH_OFFSET: rmux[7:0] = capture2_value_q[15:8];
      CAPTURE2_LOW_OFFSET:  rmux[7:0] = capture2_value_q[7:0];
      COUNTER_HIGH_OFFSET:  rmux[7:0] = count_q[15:8];
      COUNTER_LOW_OFFSET:   rmux[7:0] = count_q[7:0];
      default:              mapped = 1'b0;
    endcase
  end

  // read data sampled in setup so it comes from a flop in the access cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q  <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      rdata_q  <= apb_req.pwrite ? 32'h0000_0000 : rmux;
      slverr_q <= ~mapped;
    end
  end

  assign apb_rsp.prdata  = rdata_q;
  assign apb_rsp.pready  = access;
  assign apb_rsp.pslverr = access & slverr_q;

endmodule // timer_pulse_pwm

/* File: include/timer_pkg.sv */
// constants, field positions, modes and bus carriers for the pulse and pwm timer
package timer_pkg;

  // register byte offsets, one aligned word each, data in the low byte
  localparam logic [7:0] CONTROL_ONE_OFFSET   = 8'h00;
  localparam logic [7:0] CONTROL_TWO_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET        = 8'h08;
  localparam logic [7:0] COMPARE1_HIGH_OFFSET = 8'h0C;
  localparam logic [7:0] COMPARE1_LOW_OFFSET  = 8'h10;
  localparam logic [7:0] COMPARE2_HIGH_OFFSET = 8'h14;
  localparam logic [7:0] COMPARE2_LOW_OFFSET  = 8'h18;
  localparam logic [7:0] CAPTURE1_HIGH_OFFSET = 8'h1C;
  localparam logic [7:0] CAPTURE1_LOW_OFFSET  = 8'h20;
  localparam logic [7:0] CAPTURE2_HIGH_OFFSET = 8'h24;
  localparam logic [7:0] CAPTURE2_LOW_OFFSET  = 8'h28;
  localparam logic [7:0] COUNTER_HIGH_OFFSET  = 8'h2C;
  localparam logic [7:0] COUNTER_LOW_OFFSET   = 8'h30;

  // timer_control_one fields
  localparam int CAPTURE_IRQ_ENABLE_BIT   = 7;
  localparam int COMPARE_IRQ_ENABLE_BIT   = 6;
  localparam int COMPARE2_LEVEL_BIT       = 2;
  localparam int CAPTURE1_EDGE_SELECT_BIT = 1;
  localparam int COMPARE1_LEVEL_BIT       = 0;

  // timer_control_two fields
  localparam int COMPARE1_PIN_ENABLE_BIT  = 7;
  localparam int SINGLE_PULSE_SELECT_BIT  = 5;
  localparam int PWM_SELECT_BIT           = 4;
  localparam int TIMER_CLOCK_SELECT_LSB   = 2;
  localparam int CAPTURE2_EDGE_SELECT_BIT = 1;
  localparam int EXT_CLOCK_EDGE_BIT       = 0;

  // timer_status_reg fields
  localparam int CAPTURE1_FLAG_BIT = 7;
  localparam int COMPARE1_FLAG_BIT = 6;
  localparam int CAPTURE2_FLAG_BIT = 4;
  localparam int COMPARE2_FLAG_BIT = 3;

  // reset and reload values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
  localparam logic [15:0] COUNTER_RELOAD = 16'hFFFC;

  // timer_clock_select codes and divider terminal counts
  localparam logic [1:0] CLOCK_DIV4 = 2'h0;
  localparam logic [1:0] CLOCK_DIV2 = 2'h1;
  localparam logic [1:0] CLOCK_DIV8 = 2'h2;
  localparam logic [1:0] CLOCK_EXT  = 2'h3;
  localparam logic [2:0] DIV4_LAST  = 3'h3;
  localparam logic [2:0] DIV2_LAST  = 3'h1;
  localparam logic [2:0] DIV8_LAST  = 3'h7;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SINGLE,
    MODE_PWM
  } mode_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

endpackage

/* File: hdl/timer_tick_gen.sv */
// timer clock tick generator: cpu clock prescaler or synchronised external clock edge
module timer_tick_gen
  import timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] clock_select,
  input  wire logic       ext_edge_rising,
  input  wire logic       ext_clk_pin,
  input  wire logic       freeze,
  output logic            tick
);

  logic [2:0] div_q;
  logic [2:0] div_last;
  logic       ext_meta_q;
  logic       ext_sync_q;
  logic       ext_prev_q;
  logic       ext_hit;
  logic       div_hit;

  always_comb begin
    unique case (clock_select)
      CLOCK_DIV4: div_last = DIV4_LAST;
      CLOCK_DIV2: div_last = DIV2_LAST;
      CLOCK_DIV8: div_last = DIV8_LAST;
      CLOCK_EXT:  div_last = 3'h0;
    endcase
  end

  // at or past the end so a shorter division picked mid-count does not wait for a wrap
  assign div_hit = (div_q >= div_last);
  assign ext_hit = ext_edge_rising ? (ext_sync_q & ~ext_prev_q) : (~ext_sync_q & ext_prev_q);

  // R23
  assign tick = ~freeze & ((clock_select == CLOCK_EXT) ? ext_hit : div_hit);

  // prescaler holds in halt so counting resumes in phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_q <= 3'h0;
    end else if (freeze) begin
      div_q <= div_q;
    end else if (div_hit || clock_select == CLOCK_EXT) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // external clock is asynchronous, two flops before the edge detector
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_clk_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

endmodule // timer_tick_gen

/* File: tb/timer_pulse_pwm_sva.sv */
// port-level assertions for the pulse and pwm timer
module timer_pulse_pwm_sva
  import timer_pkg::*;
(
  input wire logic  clk,
  input wire logic  rst_b,
  input apb_req_type apb_req,
  input apb_rsp_type apb_rsp,
  input wire logic  capture1_pin,
  input wire logic  capture2_pin,
  input wire logic  ext_clk_pin,
  input wire logic  halt_state,
  input wire logic  wait_state,
  input wire logic  irq_mask,
  input wire logic  compare1_pin,
  input wire logic  compare1_pin_oe,
  input wire logic  timer_irq,
  input wire logic  wait_wake
);
  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic       wr;
  logic       single;
  logic       same_lvl;
  // mirror of the control writes, the only state the ports reveal
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign single = ctl2_q[SINGLE_PULSE_SELECT_BIT] && !ctl2_q[PWM_SELECT_BIT];
  assign same_lvl = ctl1_q[COMPARE1_LEVEL_BIT] == ctl1_q[COMPARE2_LEVEL_BIT];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl1_q <= 8'h00;
      ctl2_q <= 8'h00;
    end else if (wr) begin
      if (apb_req.paddr == CONTROL_ONE_OFFSET) ctl1_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == CONTROL_TWO_OFFSET) ctl2_q <= apb_req.pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence trig_s;
    single && !halt_state && !same_lvl && (ctl1_q[1] ? $rose(capture1_pin) : $fell(capture1_pin));
  endsequence
  wake_out_a: assert property (wait_wake == (timer_irq && wait_state))
    else $error("wake output does not follow irq and wait");
  irq_mask_a: assert property ($past(irq_mask) |-> !timer_irq)
    else $error("irq high while masked");
  oe_write_a: assert property (wr && apb_req.paddr == CONTROL_TWO_OFFSET |=>
    compare1_pin_oe == $past(apb_req.pwdata[COMPARE1_PIN_ENABLE_BIT]))
    else $error("pin enable not taken from write");
  oe_hold_a: assert property (!(wr && apb_req.paddr == CONTROL_TWO_OFFSET) |=> $stable(compare1_pin_oe))
    else $error("pin enable changed without write");
  halt_freeze_a: assert property (halt_state [*2] |-> $stable(compare1_pin))
    else $error("pin moved during halt");
  equal_level_a: assert property ((ctl2_q[5:4] != 2'h0 && same_lvl) [*3] |-> compare1_pin == ctl1_q[0])
    else $error("pin not held at common level");
  pulse_start_a: assert property (trig_s |-> ##[2:6] compare1_pin == ctl1_q[COMPARE2_LEVEL_BIT])
    else $error("trigger did not start pulse");
  pulse_irq_a: assert property (trig_s ##0 (ctl1_q[7] && !irq_mask) |-> ##[2:8] timer_irq)
    else $error("trigger did not raise irq");
  reset_out_a: assert property (disable iff (1'b0) !rst_b |=> !compare1_pin && !timer_irq && !compare1_pin_oe)
    else $error("outputs not cleared by reset");
  cover property (trig_s);
  cover property ($rose(timer_irq) && ctl2_q[PWM_SELECT_BIT]);
  cover property (halt_state [*2]);
endmodule // timer_pulse_pwm_sva

bind timer_pulse_pwm timer_pulse_pwm_sva chk (.clk(clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .capture1_pin(capture1_pin), .capture2_pin(capture2_pin), .ext_clk_pin(ext_clk_pin), .halt_state(halt_state),
  .wait_state(wait_state), .irq_mask(irq_mask), .compare1_pin(compare1_pin), .compare1_pin_oe(compare1_pin_oe),
  .timer_irq(timer_irq), .wait_wake(wait_wake));

/* File: tb/timer_pulse_pwm_test.sv */
// self-checking bench for the pulse and pwm timer
module timer_pulse_pwm_test
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] addr, wdata, rst_val, new_val; logic err;} reg_row_type;
  logic        clk;
  logic        rst_b = 1'b0;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  logic        capture1_pin = 1'b1;
  logic        capture2_pin = 1'b1;
  logic        ext_clk_pin = 1'b0;
  logic        halt_state = 1'b0;
  logic        wait_state = 1'b0;
  logic        irq_mask = 1'b0;
  logic        compare1_pin;
  logic        compare1_pin_oe;
  logic        timer_irq;
  logic        wait_wake;
  logic [31:0] rd;
  logic [31:0] rd0;
  logic        err_bit;
  int          errors = 0;
  int          cmp_count = 0;
  int          n;
  // read-only places and the unmapped word must ignore writes
  reg_row_type rows [9] = '{'{8'h00, 8'hA5, 8'h00, 8'hA5, 1'b0}, '{8'h04, 8'h08, 8'h00, 8'h08, 1'b0},
    '{8'h0C, 8'h12, 8'h80, 8'h12, 1'b0}, '{8'h10, 8'h34, 8'h00, 8'h34, 1'b0}, '{8'h14, 8'h56, 8'h80, 8'h56, 1'b0},
    '{8'h18, 8'h78, 8'h00, 8'h78, 1'b0}, '{8'h08, 8'hFF, 8'h00, 8'h00, 1'b0}, '{8'h20, 8'hFF, 8'h00, 8'h00, 1'b0},
    '{8'h40, 8'hFF, 8'h00, 8'h00, 1'b1}};
  logic [1:0]  sel [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [7:0]  step [5] = '{8'h04, 8'h08, 8'h02, 8'h02, 8'h00};

  timer_pulse_pwm uut (.clk(clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp), .capture1_pin(capture1_pin),
    .capture2_pin(capture2_pin), .ext_clk_pin(ext_clk_pin), .halt_state(halt_state), .wait_state(wait_state),
    .irq_mask(irq_mask), .compare1_pin(compare1_pin), .compare1_pin_oe(compare1_pin_oe), .timer_irq(timer_irq),
    .wait_wake(wait_wake));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one edge after release keeps a strobe from being driven twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err_bit = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask

  task reset_dut();
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  // sampled on the falling edge, where the pin has settled
  task wait_pin(input logic v);
    n = 0;
    while (compare1_pin !== v && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n == 600) errors++;
    @(posedge clk);
  endtask

  // start from a low phase so a pulse already under way is not measured short
  task pulse(input int exp);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    check(n, exp);
  endtask

  task stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    stop_test();
  end

  initial begin
    reset_dut();
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 8'h00);
      check(rd, {24'h0, rows[i].rst_val});
      apb(1'b1, rows[i].addr, rows[i].wdata);
      check({31'h0, err_bit}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].addr, 8'h00);
      check(rd, {24'h0, rows[i].new_val});
    end
    reset_dut();
    apb(1'b0, COMPARE1_HIGH_OFFSET, 8'h00);
    check(rd, 32'h80);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, CONTROL_TWO_OFFSET, {4'h0, sel[i], 2'h1});
      halt_state <= (i == 4);
      apb(1'b0, COUNTER_LOW_OFFSET, 8'h00);
      rd0 = rd;
      for (int k = 0; k < 13; k++) begin
        if (sel[i] == CLOCK_EXT) ext_clk_pin <= k[1] && (k < 8);
        @(posedge clk);
      end
      apb(1'b0, COUNTER_LOW_OFFSET, 8'h00);
      check({24'h0, rd[7:0] - rd0[7:0]}, {24'h0, step[i]});
    end
    halt_state <= 1'b0;
    apb(1'b1, COMPARE1_HIGH_OFFSET, 8'h00);
    apb(1'b1, COMPARE1_LOW_OFFSET, 8'h10);
    apb(1'b1, CONTROL_ONE_OFFSET, 8'h86);
    apb(1'b1, CONTROL_TWO_OFFSET, 8'hA4);
    capture1_pin <= 1'b0;
    repeat (10) @(posedge clk);
    check(compare1_pin, 1'b0);
    check(compare1_pin_oe, 1'b1);
    capture1_pin <= 1'b1;
    wait_pin(1'b1);
    wait_pin(1'b0);
    check(n inside {[40:44]}, 1'b1);
    check(timer_irq, 1'b1);
    apb(1'b0, CAPTURE1_LOW_OFFSET, 8'h00);
    apb(1'b0, STATUS_OFFSET, 8'h00);
    check(rd, 32'h80);
    apb(1'b0, CAPTURE1_LOW_OFFSET, 8'h00);
    apb(1'b0, STATUS_OFFSET, 8'h00);
    check(rd, 32'h00);
    check(timer_irq, 1'b0);
    apb(1'b1, CONTROL_ONE_OFFSET, 8'h05);
    repeat (4) @(posedge clk);
    check(compare1_pin, 1'b1);
    // fresh count so the first period does not wait for a wrap
    reset_dut();
    apb(1'b1, COMPARE1_HIGH_OFFSET, 8'h00);
    apb(1'b1, COMPARE1_LOW_OFFSET, 8'h10);
    apb(1'b1, COMPARE2_HIGH_OFFSET, 8'h00);
    apb(1'b1, COMPARE2_LOW_OFFSET, 8'h20);
    apb(1'b1, CONTROL_ONE_OFFSET, 8'h81);
    apb(1'b1, CONTROL_TWO_OFFSET, 8'hB4);
    pulse(32);
    wait_pin(1'b1);
    check(n, 42);
    check(timer_irq, 1'b1);
    wait_state <= 1'b1;
    capture2_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check(wait_wake, 1'b1);
    wait_state <= 1'b0;
    apb(1'b0, STATUS_OFFSET, 8'h00);
    check(rd, 32'h90);
    irq_mask <= 1'b1;
    repeat (3) @(posedge clk);
    check(timer_irq, 1'b0);
    irq_mask <= 1'b0;
    pulse(32);
    apb(1'b1, COMPARE1_LOW_OFFSET, 8'h18);
    pulse(32);
    pulse(16);
    apb(1'b1, COMPARE1_LOW_OFFSET, 8'h08);
    apb(1'b1, COMPARE1_HIGH_OFFSET, 8'h00);
    pulse(16);
    pulse(16);
    apb(1'b1, COMPARE1_LOW_OFFSET, 8'h08);
    pulse(16);
    pulse(48);
    // capture 2 flag cleared, then an edge seen only while halted
    apb(1'b0, CAPTURE2_LOW_OFFSET, 8'h00);
    halt_state <= 1'b1;
    capture2_pin <= 1'b1;
    repeat (5) @(posedge clk);
    capture2_pin <= 1'b0;
    repeat (6) @(posedge clk);
    halt_state <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, STATUS_OFFSET, 8'h00);
    check(rd, 32'h90);
    stop_test();
  end
endmodule // timer_pulse_pwm_test
